// ---- rtl/dtor_pkg.sv ----
// package: register map, field positions and reset values of the test and override bank
package dtor_pkg;
  localparam int unsigned DTOR_DW = 16;
  localparam int unsigned DTOR_AW = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_WORD5  = 8'h2A;
  localparam logic [7:0] IDX_WORD6  = 8'h2B;
  localparam logic [7:0] IDX_WORD7  = 8'h2C;
  localparam logic [7:0] IDX_CTRL   = 8'h2D;
  localparam logic [7:0] IDX_IDLY   = 8'h2E;
  localparam logic [7:0] IDX_QDLY   = 8'h2F;
  localparam logic [7:0] IDX_FORCE  = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  localparam logic [7:0] IDX_WORD0  = 8'h25;
  // reset values
  localparam logic [15:0] RST_WORD5 = 16'h1616;
  localparam logic [15:0] RST_WORD6 = 16'hAAAA;
  localparam logic [15:0] RST_WORD7 = 16'hC6C6;
  localparam logic [15:0] RST_CTRL  = 16'h0004;
  localparam logic [15:0] RST_IDLY  = 16'h0000;
  localparam logic [15:0] RST_QDLY  = 16'h0000;
  localparam logic [15:0] RST_FORCE = 16'h0000;
  // control fields
  localparam int unsigned BIT_STROBE = 14;
  localparam int unsigned BIT_RAMP   = 13;
  localparam int unsigned BIT_FORCE  = 0;
  localparam logic [15:0] CTRL_WMASK = 16'h6001;
  localparam logic [15:0] IDLY_WMASK = 16'h00FF;
  localparam logic [15:0] QDLY_WMASK = 16'hFF00;
  // status fields
  localparam int unsigned BIT_MISMATCH = 0;
  localparam int unsigned BIT_CHK_EN   = 1;
  localparam logic [15:0] STAT_WMASK  = 16'h0002;
  localparam logic [15:0] RST_STATUS  = 16'h0000;
endpackage

// ---- rtl/dtor_pattern_check.sv ----
// pattern checker: compares incoming samples against the eight-word reference
`timescale 1ns/100ps
`default_nettype none
module dtor_pattern_check
#(
  parameter int unsigned DW = 16
)
(
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // control
  input  wire logic            enable_i,
  input  wire logic [8*DW-1:0] ref_words_i,
  // sample stream
  input  wire logic            sample_valid_i,
  input  wire logic [DW-1:0]   sample_i,
  input  wire logic            frame_i,
  // result
  output logic                 mismatch_o
);
  logic [2:0]    pos_r;
  logic          frame_d_r;
  logic          mismatch_r;
  wire logic     frame_rise = frame_i & ~frame_d_r;
  // a frame rise marks word zero, so the position restarts there
  wire logic [2:0] pos_now = frame_rise ? 3'h0 : pos_r;
  wire logic [DW-1:0] expect_w = ref_words_i[pos_now*DW +: DW];
  wire logic     miss_w = enable_i & sample_valid_i & (sample_i != expect_w);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_r     <= 3'h0;
      // track the pin in reset so a marker held high is no false rise
      frame_d_r <= frame_i;
    end
    else
    begin
      frame_d_r <= frame_i;
      if (sample_valid_i)
        pos_r <= pos_now + 3'h1;
      else if (frame_rise)
        pos_r <= 3'h0;
    end
  end

  // sticky until checking is turned off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mismatch_r <= 1'b0;
    else if (miss_w)
      mismatch_r <= 1'b1;
    else if (!enable_i)
      mismatch_r <= 1'b0;
  end

  assign mismatch_o = mismatch_r;
endmodule
`default_nettype wire

// ---- rtl/dtor_regs.sv ----
// test and override register bank with wishbone slave and output path
//
// Overview of operation
// - pattern words five to seven are 16-bit registers with their own reset values.
// - strobe-routing bit 14 passes output strobe to the divider clock path.
// - ramp bit 13 replaces incoming samples with a ramp at buffer input.
// - force bit 0 drives both converters with the forced-value register.
// - forced value uses the same signed or offset format as normal data.
// - i-channel delay setting sits in bits 7:0, resets to zero.
// - q-channel delay setting sits in bits 15:8, resets to zero.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dtor_regs
#(
  parameter int unsigned DW = 16
)
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [9:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic [31:0]                 dat_o,
  output logic                        ack_o,
  // pattern words zero to four from the neighbouring bank
  input  wire logic [5*DW-1:0]        low_words_i,
  // data path
  input  wire logic                   input_data_clock_i,
  input  wire logic                   sample_valid_i,
  input  wire logic [DW-1:0]          sample_i_i,
  input  wire logic [DW-1:0]          sample_q_i,
  input  wire logic                   frame_i,
  input  wire logic                   twos_format_i,
  input  wire logic                   output_strobe_i,
  input  wire logic                   divider_clock_i,
  // outputs to the converter core
  output logic [DW-1:0]               converter_i_o,
  output logic [DW-1:0]               converter_q_o,
  output logic [DW-1:0]               buffer_i_o,
  output logic [DW-1:0]               buffer_q_o,
  output logic                        divider_clock_o,
  output logic [7:0]                  i_channel_delay_setting_o,
  output logic [7:0]                  q_channel_delay_setting_o,
  output logic                        mismatch_o
);
  import dtor_pkg::*;

  // ==========================================================
  // register storage
  logic [15:0]   word5_r;
  logic [15:0]   word6_r;
  logic [15:0]   word7_r;
  logic [15:0]   ctrl_r;
  logic [15:0]   idly_r;
  logic [15:0]   qdly_r;
  logic [15:0]   force_r;
  logic          chk_en_r;
  logic          ack_r;
  logic [31:0]   rdat_r;
  logic [DW-1:0] conv_i_r;
  logic [DW-1:0] conv_q_r;
  logic [DW-1:0] buf_i_r;
  logic [DW-1:0] buf_q_r;
  logic [DW-1:0] ramp_r;
  logic          div_clk_r;
  logic          dclk_d_r;
  logic          mismatch_w;

  // ==========================================================
  // bus decode
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] lane;
    lane = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    merge = (lane & mask) | (old & ~mask);
  endfunction

  wire logic       req_w   = cyc_i & stb_i & ~ack_r;
  wire logic       wr_w    = req_w & we_i;
  wire logic [7:0] idx_w   = adr_i[9:2];
  wire logic       hit5    = wr_w & (idx_w == IDX_WORD5);
  wire logic       hit6    = wr_w & (idx_w == IDX_WORD6);
  wire logic       hit7    = wr_w & (idx_w == IDX_WORD7);
  wire logic       hitc    = wr_w & (idx_w == IDX_CTRL);
  wire logic       hiti    = wr_w & (idx_w == IDX_IDLY);
  wire logic       hitq    = wr_w & (idx_w == IDX_QDLY);
  wire logic       hitf    = wr_w & (idx_w == IDX_FORCE);
  wire logic       hits    = wr_w & (idx_w == IDX_STATUS);
  wire logic [15:0] status_w = {14'h0, chk_en_r, mismatch_w};

  // unmapped reads return zero, writes there are dropped
  wire logic [15:0] rsel_w =
    (idx_w == IDX_WORD5)  ? word5_r  :
    (idx_w == IDX_WORD6)  ? word6_r  :
    (idx_w == IDX_WORD7)  ? word7_r  :
    (idx_w == IDX_CTRL)   ? ctrl_r   :
    (idx_w == IDX_IDLY)   ? idly_r   :
    (idx_w == IDX_QDLY)   ? qdly_r   :
    (idx_w == IDX_FORCE)  ? force_r  :
    (idx_w == IDX_STATUS) ? status_w : 16'h0000;

  // ==========================================================
  // wishbone handshake: one wait state, ack for one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r  <= req_w;
      rdat_r <= req_w ? {16'h0000, rsel_w} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // register writes; byte lanes merge through the write masks
  wire logic [15:0] word5_nxt  = merge(word5_r, dat_i, sel_i, 16'hFFFF);
  wire logic [15:0] word6_nxt  = merge(word6_r, dat_i, sel_i, 16'hFFFF);
  wire logic [15:0] word7_nxt  = merge(word7_r, dat_i, sel_i, 16'hFFFF);
  wire logic [15:0] ctrl_nxt   = merge(ctrl_r, dat_i, sel_i, CTRL_WMASK);
  wire logic [15:0] idly_nxt   = merge(idly_r, dat_i, sel_i, IDLY_WMASK);
  wire logic [15:0] qdly_nxt   = merge(qdly_r, dat_i, sel_i, QDLY_WMASK);
  wire logic [15:0] force_nxt  = merge(force_r, dat_i, sel_i, 16'hFFFF);
  // only byte lane zero carries the enable; the mismatch bit is read-only
  wire logic        chk_en_nxt = sel_i[0] ? dat_i[BIT_CHK_EN] : chk_en_r;

  // pattern words five to seven
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word5_r <= RST_WORD5;
      word6_r <= RST_WORD6;
      word7_r <= RST_WORD7;
    end
    else
    begin
      if (hit5)
        word5_r <= word5_nxt;
      if (hit6)
        word6_r <= word6_nxt;
      if (hit7)
        word7_r <= word7_nxt;
    end
  end

  // test and override control; reserved bits keep their reset value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= RST_CTRL;
    else if (hitc)
      ctrl_r <= ctrl_nxt;
  end

  // group delay settings, one byte each in opposite halves
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idly_r <= RST_IDLY;
      qdly_r <= RST_QDLY;
    end
    else
    begin
      if (hiti)
        idly_r <= idly_nxt;
      if (hitq)
        qdly_r <= qdly_nxt;
    end
  end

  // forced output value and checker enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      force_r  <= RST_FORCE;
      chk_en_r <= 1'b0;
    end
    else
    begin
      if (hitf)
        force_r <= force_nxt;
      if (hits)
        chk_en_r <= chk_en_nxt;
    end
  end

  // ==========================================================
  // control decode
  wire logic ramp_on   = ctrl_r[BIT_RAMP];
  wire logic force_on  = ctrl_r[BIT_FORCE];
  wire logic strobe_on = ctrl_r[BIT_STROBE];
  // data clock is sampled as a plain input; a rise latches the force value
  wire logic dclk_rise = input_data_clock_i & ~dclk_d_r;
  // offset binary is two's complement with the sign bit flipped
  function automatic logic [DW-1:0] core_fmt(input logic [DW-1:0] v, input logic twos);
    core_fmt = twos ? v : {~v[DW-1], v[DW-2:0]};
  endfunction

  wire logic [DW-1:0] force_fmt   = core_fmt(force_r[DW-1:0], twos_format_i);
  wire logic [DW-1:0] in_i        = ramp_on ? ramp_r : sample_i_i;
  wire logic [DW-1:0] in_q        = ramp_on ? ramp_r : sample_q_i;
  wire logic [DW-1:0] ramp_nxt    = ramp_on ? ramp_r + 1'b1 : '0;
  wire logic          div_clk_nxt = strobe_on ? output_strobe_i : divider_clock_i;

  // ==========================================================
  // data path: divider clock source and data clock edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // follow the pin in reset so a clock parked high gives no false edge
      dclk_d_r  <= input_data_clock_i;
      div_clk_r <= 1'b0;
    end
    else
    begin
      dclk_d_r  <= input_data_clock_i;
      div_clk_r <= div_clk_nxt;
    end
  end

  // ==========================================================
  // ramp source: counts valid samples, restarts when switched off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ramp_r <= '0;
    else if (sample_valid_i)
      ramp_r <= ramp_nxt;
  end

  // ==========================================================
  // elastic buffer input
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      buf_i_r <= '0;
      buf_q_r <= '0;
    end
    else if (sample_valid_i)
    begin
      buf_i_r <= in_i;
      buf_q_r <= in_q;
    end
  end

  // ==========================================================
  // converter outputs: forced value or formatted data
  // forced value only moves when the data clock runs
  wire logic          conv_load  = force_on ? dclk_rise : sample_valid_i;
  wire logic [DW-1:0] conv_i_nxt = force_on ? force_fmt : core_fmt(in_i, twos_format_i);
  wire logic [DW-1:0] conv_q_nxt = force_on ? force_fmt : core_fmt(in_q, twos_format_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_i_r <= '0;
      conv_q_r <= '0;
    end
    else if (conv_load)
    begin
      conv_i_r <= conv_i_nxt;
      conv_q_r <= conv_q_nxt;
    end
  end

  // ==========================================================
  // pattern checker on the I lane
  dtor_pattern_check #(.DW(DW)) u_check
  (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .enable_i       (chk_en_r),
    .ref_words_i    ({word7_r, word6_r, word5_r, low_words_i}),
    .sample_valid_i (sample_valid_i),
    .sample_i       (sample_i_i),
    .frame_i        (frame_i),
    .mismatch_o     (mismatch_w)
  );

  // ==========================================================
  // outputs
  logic mis_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mis_r <= 1'b0;
    else
      mis_r <= mismatch_w;
  end

  assign dat_o                     = rdat_r;
  assign ack_o                     = ack_r;
  assign converter_i_o             = conv_i_r;
  assign converter_q_o             = conv_q_r;
  assign buffer_i_o                = buf_i_r;
  assign buffer_q_o                = buf_q_r;
  assign divider_clock_o           = div_clk_r;
  assign i_channel_delay_setting_o = idly_r[7:0];
  assign q_channel_delay_setting_o = qdly_r[15:8];
  assign mismatch_o                = mis_r;
endmodule
`default_nettype wire

// ---- tb/dtor_regs_props.sv ----
// checker: bus handshake, delay fields, divider routing and reset of the bank
`timescale 1ns/100ps
`default_nettype none
module dtor_regs_props
  import dtor_pkg::*;
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        output_strobe_i,
  input wire logic        divider_clock_i,
  input wire logic        divider_clock_o,
  input wire logic [15:0] converter_i_o,
  input wire logic [7:0]  i_channel_delay_setting_o,
  input wire logic [7:0]  q_channel_delay_setting_o
);
  // ==========
  // helpers
  wire logic       take = cyc_i && stb_i && !ack_o;
  wire logic [7:0] idx  = adr_i[9:2];
  // shadow of the strobe-routing bit, taken at the edge the bank stores it
  logic            strobe_sel_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      strobe_sel_r <= 1'b0;
    else if (take && we_i && sel_i[1] && idx == IDX_CTRL)
      strobe_sel_r <= dat_i[BIT_STROBE];
  end
  wire logic       div_src = strobe_sel_r ? output_strobe_i : divider_clock_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // assertions
  a_ack_answer: assert property (take |=> ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (take && !we_i && idx > IDX_STATUS |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_idly_write: assert property (take && we_i && sel_i[0] && idx == IDX_IDLY
    |-> ##2 i_channel_delay_setting_o == $past(dat_i[7:0], 2)) else $error("i delay wrong");
  a_qdly_write: assert property (take && we_i && sel_i[1] && idx == IDX_QDLY
    |-> ##2 q_channel_delay_setting_o == $past(dat_i[15:8], 2)) else $error("q delay wrong");
  a_reset_quiet: assert property ($past(rst_i) |-> !ack_o && converter_i_o == 16'h0
    && i_channel_delay_setting_o == 8'h0 && q_channel_delay_setting_o == 8'h0)
    else $error("outputs not cleared by reset");
  a_divclk_source: assert property (!$past(rst_i) |-> divider_clock_o == $past(div_src))
    else $error("divider clock source");
endmodule
bind dtor_regs dtor_regs_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .output_strobe_i, .divider_clock_i, .divider_clock_o, .converter_i_o,
  .i_channel_delay_setting_o, .q_channel_delay_setting_o);
`default_nettype wire

// ---- tb/tb.sv ----
// testbench: register map, override paths and pattern checker
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dtor_pkg::*;
  // ==========
  // signals
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, input_data_clock_i, sample_valid_i;
  logic        frame_i, twos_format_i, output_strobe_i, divider_clock_i, divider_clock_o;
  logic        mismatch_o;
  logic [9:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [79:0] low_words_i;
  logic [15:0] sample_i_i, sample_q_i, converter_i_o, converter_q_o, buffer_i_o, buffer_q_o;
  logic [15:0] wv [8];
  logic [15:0] d;
  logic [7:0]  i_channel_delay_setting_o, q_channel_delay_setting_o, ix;
  int          n_mismatch, tests_run, k;
  localparam logic [15:0] RV [7] = '{RST_WORD5, RST_WORD6, RST_WORD7, RST_CTRL, RST_IDLY,
    RST_QDLY, RST_FORCE};
  dtor_regs u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .low_words_i, .input_data_clock_i, .sample_valid_i, .sample_i_i, .sample_q_i,
    .frame_i, .twos_format_i, .output_strobe_i, .divider_clock_i, .converter_i_o,
    .converter_q_o, .buffer_i_o, .buffer_q_o, .divider_clock_o, .i_channel_delay_setting_o,
    .q_channel_delay_setting_o, .mismatch_o);
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ==========
  // expectations and checks
  function automatic logic [15:0] rb(input logic [7:0] i, input logic [15:0] v);
    case (i)
      IDX_CTRL: return (v & CTRL_WMASK) | (RST_CTRL & ~CTRL_WMASK);
      IDX_IDLY: return v & IDLY_WMASK;
      IDX_QDLY: return v & QDLY_WMASK;
      default:  return v;
    endcase
  endfunction
  // offset binary flips the sign bit only
  function automatic logic [15:0] fmt(input logic [15:0] v, input logic t);
    return t ? v : v ^ 16'h8000;
  endfunction
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %0t: reg %h exp %h", $time, g, e);
      n_mismatch++;
    end
  endtask
  task automatic chk_out(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %0t: out %h exp %h", $time, g, e);
      n_mismatch++;
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // bus and sample drivers
  task automatic wb(input logic w, input logic [7:0] i, input logic [15:0] v);
    int t;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    dat_i <= {16'h0000, v};
    @(posedge clk_i);
    for (t = 0; t < 20 && ack_o !== 1'b1; t++)
      @(posedge clk_i);
    if (t == 20)
    begin
      $display("ERROR %0t: no ack", $time);
      n_mismatch++;
      results();
    end
    else
    begin
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask
  task automatic smp(input logic [15:0] s, input logic f);
    @(posedge clk_i);
    sample_valid_i <= 1'b1;
    sample_i_i <= s;
    sample_q_i <= s;
    frame_i <= f;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    frame_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // ==========
  // main sequence
  initial
  begin
    {cyc_i, stb_i, we_i, input_data_clock_i, sample_valid_i, frame_i, adr_i, dat_i} = '0;
    {twos_format_i, output_strobe_i, divider_clock_i, sample_i_i, sample_q_i} = '0;
    sel_i = 4'h3;
    rst_i = 1'b1;
    n_mismatch = 0;
    tests_run = $urandom(61510);
    tests_run = 0;
    for (k = 0; k < 8; k++)
      wv[k] = 16'($urandom);
    low_words_i = {wv[4], wv[3], wv[2], wv[1], wv[0]};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k < 7; k++)
    begin
      wb(1'b0, IDX_WORD5 + 8'(k), 16'h0);
      chk_reg(q, {16'h0, RV[k]});
    end
    for (k = 0; k < 24; k++)
    begin
      ix = (k == 23) ? 8'h40 : IDX_WORD5 + 8'(k % 7);
      d = (k < 7) ? 16'hFFFF : 16'($urandom);
      wb(1'b1, ix, d);
      wb(1'b0, ix, 16'h0);
      chk_reg(q, (k == 23) ? 32'h0 : {16'h0, rb(ix, d)});
    end
    wb(1'b1, IDX_IDLY, d);
    wb(1'b1, IDX_QDLY, d);
    q = {16'h0, i_channel_delay_setting_o, q_channel_delay_setting_o};
    chk_out(q, {16'h0, d[7:0], d[15:8]});
    // byte lane zero alone: the high byte must survive
    wb(1'b1, IDX_WORD5, 16'hFFFF);
    sel_i <= 4'h1;
    wb(1'b1, IDX_WORD5, 16'h0000);
    sel_i <= 4'h3;
    wb(1'b0, IDX_WORD5, 16'h0);
    chk_reg(q, 32'h0000_FF00);
    for (k = 5; k < 8; k++)
      wb(1'b1, IDX_WORD5 + 8'(k - 5), wv[k]);
    d = 16'($urandom);
    wb(1'b1, IDX_FORCE, d);
    wb(1'b1, IDX_CTRL, 16'h0001);
    for (k = 0; k < 2; k++)
    begin
      twos_format_i <= k[0];
      @(posedge clk_i);
      input_data_clock_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      input_data_clock_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk_out({converter_i_o, converter_q_o}, {2{fmt(d, k[0])}});
    end
    for (k = 0; k < 4; k++)
    begin
      wb(1'b1, IDX_CTRL, {1'b0, k[1], 14'h0});
      output_strobe_i <= k[0];
      divider_clock_i <= ~k[0];
      repeat (3) @(posedge clk_i);
      chk_out(32'(divider_clock_o), {31'h0, k[1] ? k[0] : ~k[0]});
    end
    wb(1'b1, IDX_CTRL, 16'h2000);
    for (k = 0; k < 3; k++)
    begin
      smp(16'($urandom), 1'b0);
      chk_out({buffer_i_o, buffer_q_o}, {2{16'(k)}});
    end
    wb(1'b1, IDX_CTRL, 16'h0000);
    twos_format_i <= 1'b0;
    smp(d, 1'b0);
    chk_out({buffer_i_o, converter_q_o}, {d, fmt(d, 1'b0)});
    chk_out({buffer_q_o, converter_i_o}, {d, fmt(d, 1'b0)});
    wb(1'b1, IDX_STATUS, 16'h0002);
    for (k = 0; k < 16; k++)
      smp(wv[k % 8], k % 8 == 0);
    chk_out(32'(mismatch_o), 32'h0);
    smp(wv[0] ^ 16'h0001, 1'b1);
    chk_out(32'(mismatch_o), 32'h1);
    wb(1'b0, IDX_STATUS, 16'h0);
    chk_reg(q, 32'h3);
    wb(1'b1, IDX_STATUS, 16'h0);
    repeat (4) @(posedge clk_i);
    chk_out(32'(mismatch_o), 32'h0);
    results();
  end
endmodule
`default_nettype wire
